// ==== design/adm_pkg.sv ====
// Purpose: Shared constants for the converter mode and result access block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Offsets and layouts of the software visible registers
package adm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00; // converter_control_register
  localparam logic [7:0] OFF_IEN2    = 8'h04; // second_interrupt_enable_register
  localparam logic [7:0] OFF_RESULT  = 8'h08; // Conversion result, read only
  localparam logic [7:0] OFF_WORK    = 8'h0C; // Work register
  localparam logic [7:0] OFF_CMD     = 8'h10; // Instruction strobe register
  localparam logic [7:0] OFF_PORT    = 8'h14; // Port latches and analog select
  localparam logic [7:0] OFF_PIN     = 8'h18; // Port input path, read only
  localparam logic [7:0] OFF_IRQ_ST  = 8'h1C; // Sticky event status
  localparam logic [7:0] OFF_IRQ_MSK = 8'h20; // Event mask
  localparam logic [7:0] OFF_ADIN    = 8'h24; // Converter start; reads back done, busy, mode

  // Field positions
  localparam int BIT_MODE      = 3; // Control: 0 conversion, 1 comparator
  localparam int BIT_ADC_IEN   = 2; // Second enable register: converter irq
  localparam int BIT_CMD_XFER  = 0; // Command: result transfer
  localparam int BIT_CMD_TEST  = 1; // Command: done test
  localparam int BIT_EV_DONE   = 0; // Status: done flag seen set
  localparam int BIT_EV_SKIP   = 1; // Status: test instruction skipped
  localparam int BIT_EV_SPUR   = 2; // Status: mode switch set the flag

  // Reset values
  localparam logic [3:0] CTRL_RST   = 4'h0;
  localparam logic [3:0] IEN2_RST   = 4'h0;
  localparam logic [3:0] PORT_RST   = 4'hF;
  localparam logic [2:0] MSK_RST    = 3'h0;

  // Converter busy time in cycles
  localparam int BUSY_CYCLES = 16;

  typedef enum logic [1:0]
  {
    ADM_IDLE = 2'b00,
    ADM_BUSY = 2'b01
  } adm_state_t;

endpackage : adm_pkg

// ==== design/adm_sync.sv ====
// Purpose: Two-flip-flop synchroniser for the shared pin inputs
// Assumes: Inputs come from pins outside the clock domain
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module adm_sync
  import adm_pkg::*;
#(
  parameter int W = 4
)
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // Two stage capture
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      q_out  <= '0;
    end
    else
    begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule : adm_sync

// ==== design/adm_top.sv ====
// Purpose: Converter mode switch, done flag, result transfer, shared pins
// Assumes: APB slave on CLK_IN, synchronous active high RST_IN
// Notes:   Analog core is outside; its done pulse enters on an input
//
// How it works
// R1 - Shared pins stay ordinary port bits always
// R2 - Port input of analog pin undefined
// R3 - Software sets analog pins' latch to one
// R4 - Transfer: result low two bits to work top
// R5 - Control bit 3 picks conversion or comparator
// R6 - Software keeps mode still while busy
// R7 - Comparator-to-conversion switch may set done flag
// R8 - Software disables converter irq before switch
// R9 - Software runs done test after switch
// R10 - Done test acts only when irq disabled
// R11 - Mode zero conversion, one comparator
// R12 - Done test clears flag and skips
`timescale 1ns/1ps
module adm_top
  import adm_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        ADC_DONE_IN,    // Converter finished, one cycle
  input  wire logic [9:0]  ADC_RESULT_IN,  // Result from analog core
  input  wire logic [3:0]  PIN_IN,         // Pins: 2nd port b0,b1, 3rd b0,b1
  output logic      [3:0]  PIN_OUT,
  output logic      [3:0]  PIN_OE_N_OUT,   // Low while driving
  output logic      [3:0]  ANALOG_SEL_OUT,
  output logic             MODE_OUT,
  output logic             SKIP_OUT,       // Next instruction skipped, pulse
  output logic             ADC_IRQ_OUT,    // Converter interrupt request
  output logic             IRQ_OUT
);

  logic [3:0]  ctrl_q;
  logic [3:0]  ien2_q;
  logic [9:0]  result_q;
  logic [3:0]  work_q;
  logic [3:0]  latch_q;
  logic [3:0]  dir_q;
  logic [3:0]  asel_q;
  logic        done_q;
  logic [2:0]  irq_st_q;
  logic [2:0]  irq_msk_q;
  logic [31:0] prdata_q;
  logic        skip_q;
  logic [4:0]  busy_cnt_q;
  adm_state_t  state_q;
  logic [3:0]  pin_sync;

  // Pin inputs pass two flops before use
  adm_sync #(.W(4)) u_sync
  (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .d_in   (PIN_IN),
    .q_out  (pin_sync)
  );

  // Bus decode
  wire acc     = PSEL_IN & PENABLE_IN;
  wire wr      = acc & PWRITE_IN;
  wire rd      = acc & ~PWRITE_IN;
  wire hit_ctl = (PADDR_IN == OFF_CTRL);
  wire hit_ien = (PADDR_IN == OFF_IEN2);
  wire hit_res = (PADDR_IN == OFF_RESULT);
  wire hit_wrk = (PADDR_IN == OFF_WORK);
  wire hit_cmd = (PADDR_IN == OFF_CMD);
  wire hit_prt = (PADDR_IN == OFF_PORT);
  wire hit_pin = (PADDR_IN == OFF_PIN);
  wire hit_ist = (PADDR_IN == OFF_IRQ_ST);
  wire hit_msk = (PADDR_IN == OFF_IRQ_MSK);
  wire hit_adi = (PADDR_IN == OFF_ADIN);
  wire mapped  = hit_ctl | hit_ien | hit_res | hit_wrk | hit_cmd | hit_prt
               | hit_pin | hit_ist | hit_msk | hit_adi;

  // Control bits and instruction strobes
  wire       ctrl_wr   = wr & hit_ctl;
  wire       new_mode  = PWDATA_IN[BIT_MODE];                 // R11
  wire       mode_cmp  = ctrl_q[BIT_MODE];                    // R5
  wire       to_conv   = ctrl_wr & mode_cmp & ~new_mode;      // R7
  wire       irq_en    = ien2_q[BIT_ADC_IEN];
  wire       do_xfer   = wr & hit_cmd & PWDATA_IN[BIT_CMD_XFER];
  wire       do_test   = wr & hit_cmd & PWDATA_IN[BIT_CMD_TEST] & ~irq_en; // R10
  wire       test_skip = do_test & done_q;                    // R12
  wire       start     = wr & hit_adi & PWDATA_IN[0];
  wire       busy      = (state_q == ADM_BUSY);
  wire       fin       = ADC_DONE_IN | (busy & (busy_cnt_q == 5'h00));
  wire       set_done  = fin | to_conv;                       // R7
  wire [2:0] ev        = {to_conv, test_skip, set_done};

  // Converter mode and enable registers; mode ignored while busy
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      ctrl_q <= CTRL_RST;
      ien2_q <= IEN2_RST;
    end
    else
    begin
      if (ctrl_wr & ~busy)
        ctrl_q <= PWDATA_IN[3:0];                             // R5
      if (wr & hit_ien)
        ien2_q <= PWDATA_IN[3:0];
    end
  end

  // Conversion timer
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      state_q    <= ADM_IDLE;
      busy_cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        ADM_IDLE:
        begin
          if (start)
          begin
            state_q    <= ADM_BUSY;
            busy_cnt_q <= 5'(BUSY_CYCLES - 1);
          end
        end
        ADM_BUSY:
        begin
          if (busy_cnt_q == 5'h00)
            state_q <= ADM_IDLE;
          else
            busy_cnt_q <= busy_cnt_q - 5'h01;
        end
        default:
          state_q <= ADM_IDLE;
      endcase
    end
  end

  // Done flag: a setting event beats the test clear
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      done_q <= 1'b0;
    else if (set_done)
      done_q <= 1'b1;                                         // R7
    else if (test_skip)
      done_q <= 1'b0;                                         // R12
  end

  // Result capture and work register transfer
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      result_q <= 10'h000;
      work_q   <= 4'h0;
    end
    else
    begin
      if (ADC_DONE_IN)
        result_q <= ADC_RESULT_IN;
      if (do_xfer)
        work_q <= {result_q[1:0], 2'b00};                     // R4
      else if (wr & hit_wrk)
        work_q <= PWDATA_IN[3:0];
    end
  end

  // Port latches, directions, analog selects: port stays live
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      latch_q <= PORT_RST;
      dir_q   <= 4'h0;
      asel_q  <= 4'h0;
    end
    else if (wr & hit_prt)
    begin
      latch_q <= PWDATA_IN[3:0];                              // R1
      dir_q   <= PWDATA_IN[7:4];
      asel_q  <= PWDATA_IN[11:8];
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      irq_st_q  <= 3'h0;
      irq_msk_q <= MSK_RST;
    end
    else
    begin
      irq_st_q <= ev | (irq_st_q & ~((wr & hit_ist) ? PWDATA_IN[2:0] : 3'h0));
      if (wr & hit_msk)
        irq_msk_q <= PWDATA_IN[2:0];
    end
  end

  // Read data and skip pulse
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      prdata_q <= 32'h0000_0000;
      skip_q   <= 1'b0;
    end
    else
    begin
      skip_q <= test_skip;
      if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN)
      begin
        if (hit_ctl)
          prdata_q <= {28'h0, ctrl_q};
        else if (hit_ien)
          prdata_q <= {28'h0, ien2_q};
        else if (hit_res)
          prdata_q <= {22'h0, result_q};
        else if (hit_wrk)
          prdata_q <= {28'h0, work_q};
        else if (hit_prt)
          prdata_q <= {20'h0, asel_q, dir_q, latch_q};
        else if (hit_pin)
          prdata_q <= {28'h0, pin_sync};                      // R2
        else if (hit_ist)
          prdata_q <= {29'h0, irq_st_q};
        else if (hit_msk)
          prdata_q <= {29'h0, irq_msk_q};
        else if (hit_adi)
          prdata_q <= {29'h0, done_q, busy, mode_cmp};
        else
          prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Outputs
  assign PRDATA_OUT     = prdata_q;
  assign PREADY_OUT     = 1'b1;
  assign PSLVERR_OUT    = acc & ~mapped;
  assign PIN_OUT        = latch_q;                            // R1
  assign PIN_OE_N_OUT   = ~dir_q;
  assign ANALOG_SEL_OUT = asel_q;
  assign MODE_OUT       = mode_cmp;
  assign SKIP_OUT       = skip_q;
  assign ADC_IRQ_OUT    = done_q & irq_en;
  assign IRQ_OUT        = |(irq_st_q & irq_msk_q);

  wire unused_ok = rd;

endmodule : adm_top

// ==== verification/adm_pins_model.sv ====
// Purpose: Shared pin sources and analog core
// Assumes: Same clock as the block
// Notes:   Result shows inverse after the pulse
`timescale 1ns/1ps
module adm_pins_model
(
  input  wire logic       clk_in,
  input  wire logic [3:0] pin_out_in,
  input  wire logic [3:0] oe_n_in,
  input  wire logic [3:0] ext_in,
  output logic      [3:0] pin_in_out,
  output logic            done_out,
  output logic      [9:0] result_out
);
  // Block wins where it drives, source elsewhere
  assign pin_in_out = (~oe_n_in & pin_out_in) | (oe_n_in & ext_in);
  initial
  begin
    done_out   = 1'b0;
    result_out = 10'h000;
  end
  // One-cycle done pulse with a result
  task automatic finish(input logic [9:0] v);
    @(posedge clk_in);
    done_out   <= 1'b1;
    result_out <= v;
    @(posedge clk_in);
    done_out   <= 1'b0;
    result_out <= ~v;
  endtask : finish
endmodule : adm_pins_model

// ==== verification/adm_properties.sv ====
// Purpose: Port properties of adm_top
// Assumes: Software never writes the mode while the converter is busy
// Notes:   Bound below
`timescale 1ns/1ps
module adm_properties
  import adm_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        PSLVERR_OUT,
  input wire logic [3:0]  PIN_OUT,
  input wire logic [3:0]  PIN_OE_N_OUT,
  input wire logic [3:0]  ANALOG_SEL_OUT,
  input wire logic        MODE_OUT,
  input wire logic        SKIP_OUT
);
  // Access decode
  wire acc = PSEL_IN && PENABLE_IN;
  wire wr  = acc && PWRITE_IN;
  wire map = PADDR_IN <= OFF_ADIN && PADDR_IN[1:0] == 2'h0;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_port; wr && PADDR_IN == OFF_PORT; endsequence
  property p_err; acc && !map |-> PSLVERR_OUT; endproperty
  property p_noerr; PSLVERR_OUT |-> acc && !map; endproperty
  property p_mode; wr && PADDR_IN == OFF_CTRL |=> MODE_OUT == $past(PWDATA_IN[BIT_MODE]);
  endproperty
  property p_mhold; !$stable(MODE_OUT) |-> $past(wr && PADDR_IN == OFF_CTRL); endproperty
  property p_port; s_port |=> PIN_OUT == $past(PWDATA_IN[3:0])
    && PIN_OE_N_OUT == ~$past(PWDATA_IN[7:4]) && ANALOG_SEL_OUT == $past(PWDATA_IN[11:8]);
  endproperty
  property p_phold; !$stable(PIN_OUT) |-> $past(wr && PADDR_IN == OFF_PORT); endproperty
  property p_skip; SKIP_OUT |-> $past(wr && PADDR_IN == OFF_CMD && PWDATA_IN[BIT_CMD_TEST]);
  endproperty
  property p_pulse; SKIP_OUT |=> !SKIP_OUT; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  a_noerr: assert property (p_noerr) else $error("stray slverr");
  a_mode: assert property (p_mode) else $error("mode value");
  a_mhold: assert property (p_mhold) else $error("mode moved");
  a_port: assert property (p_port) else $error("port fields");
  a_phold: assert property (p_phold) else $error("latch moved");
  a_skip: assert property (p_skip) else $error("stray skip");
  a_pulse: assert property (p_pulse) else $error("long skip");
endmodule : adm_properties
bind adm_top adm_properties i_props (.*);

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for adm_top
// Assumes: Software keeps the mode still while the converter is busy
// Notes:   Int model tracks flag and skips
`timescale 1ns/1ps
module tb_top;
  import adm_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, es;
  logic [7:0]  pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic        rdy, err, skip, airq, irq, mode, done;
  logic [3:0]  po, oen, asel, pin, ext = 0, lat;
  logic [9:0]  res, r;
  int          error_cnt = 0, num_checks = 0, skips = 0, m_skips = 0, m_flag = 0, m_ien = 0;
  adm_top i_dut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
    .PSLVERR_OUT(err), .ADC_DONE_IN(done), .ADC_RESULT_IN(res), .PIN_IN(pin),
    .PIN_OUT(po), .PIN_OE_N_OUT(oen), .ANALOG_SEL_OUT(asel), .MODE_OUT(mode),
    .SKIP_OUT(skip), .ADC_IRQ_OUT(airq), .IRQ_OUT(irq));
  adm_pins_model i_pm (.clk_in(clk), .pin_out_in(po), .oe_n_in(oen), .ext_in(ext),
    .pin_in_out(pin), .done_out(done), .result_out(res));
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Count skip pulses
  always @(posedge clk) if (skip === 1'b1) skips++;
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // APB transfer held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = prd;
    es = err;
    psel <= 0;
    pen  <= 0;
    @(posedge clk);
  endtask : apb
  // Done test against the model
  task automatic tst;
    if (m_flag && !m_ien)
    begin
      m_skips++;
      m_flag = 0;
    end
    apb(1, OFF_CMD, 32'h2);
    @(posedge clk);
    chk(skips, m_skips, "skip");
  endtask : tst
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h3B0AD268));
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk({mode, po, oen, asel}, {1'b0, 12'hFF0}, "reset");
    lat = 4'($urandom) | 4'h5;
    ext <= 4'($urandom);
    apb(1, OFF_PORT, {20'h0, 4'h5, 4'h3, lat});
    chk({po, oen, asel}, {lat, 8'hC5}, "port");
    repeat (3) @(posedge clk);
    apb(0, OFF_PIN, 0);
    chk(rd & 32'hA, {ext[3], 1'b0, lat[1], 1'b0}, "pin");
    apb(1, OFF_IEN2, 0);
    apb(1, OFF_CTRL, 32'h8);
    chk(mode, 1, "cmp");
    apb(1, OFF_CTRL, 0);
    m_flag = 1;
    chk(mode, 0, "conv");
    tst();
    tst();
    apb(1, OFF_IEN2, 32'h4);
    m_ien = 1;
    i_pm.finish(10'h155);
    m_flag = 1;
    @(posedge clk);
    tst();
    chk(airq, 1, "airq");
    apb(1, OFF_IEN2, 0);
    m_ien = 0;
    tst();
    repeat (3)
    begin
      r = 10'($urandom);
      apb(1, OFF_WORK, 32'($urandom));
      i_pm.finish(r);
      m_flag = 1;
      apb(1, OFF_CMD, 32'h1);
      apb(0, OFF_WORK, 0);
      chk(rd, {r[1:0], 2'b00}, "work");
    end
    // Timed conversion: mode is only touched once the converter is idle again
    apb(1, OFF_ADIN, 32'h1);
    apb(0, OFF_ADIN, 0);
    chk(rd[1], 1, "busy");
    repeat (BUSY_CYCLES) @(posedge clk);
    apb(0, OFF_ADIN, 0);
    m_flag = 1;
    chk(rd[2:1], 2'b10, "idle done");
    apb(1, OFF_CTRL, 32'h8);
    chk(mode, 1, "cmp after busy");
    apb(1, OFF_CTRL, 0);
    chk(mode, 0, "conv after busy");
    tst();
    apb(0, OFF_IRQ_ST, 0);
    chk(rd, 7, "status");
    chk(irq, 0, "masked");
    apb(1, OFF_IRQ_MSK, 7);
    chk(irq, 1, "irq");
    apb(1, OFF_IRQ_ST, 7);
    chk(irq, 0, "clear");
    apb(0, 8'h3C, 0);
    chk(es, 1, "slverr");
    chk(rd, 0, "unmapped");
    end_of_test();
  end
endmodule : tb_top
